// File: dsap_cfg.svh
`ifndef DSAP_CFG_SVH
`define DSAP_CFG_SVH
// instruction codes
`define DSAP_IR_W 4
`define DSAP_IR_EXTEST 4'h0
`define DSAP_IR_IDCODE 4'h1
`define DSAP_IR_SAMPLE 4'h2
`define DSAP_IR_DBG0 4'h8
`define DSAP_IR_DBG1 4'h9
`define DSAP_IR_DBG2 4'ha
`define DSAP_IR_DBG3 4'hb
`define DSAP_IR_SRESET 4'hc
`define DSAP_IR_BYPASS 4'hf
`define DSAP_IR_CAPTURE 4'h1
// identification word, arbitrary neutral values
`define DSAP_ID_VERSION 4'h3
`define DSAP_ID_PART 16'h5a5a
`define DSAP_ID_MAKER 11'h2a6
// boundary ring and breakpoint widths
`define DSAP_NPINS 8
`define DSAP_BSR_W 24
`define DSAP_ADDR_W 16
`define DSAP_NBP 4
// debug chain layout: 4 x (addr 16 + en 1 + data 1) + mode 2 + flow 1 + step 1
`define DSAP_BPC_W 76
`define DSAP_BP_MODE_LSB 72
`define DSAP_BP_FLOW_BIT 74
`define DSAP_BP_STEP_BIT 75
`define DSAP_CPU_W 16
`define DSAP_MSG_W 8
`define DSAP_MSG_DIRTY_BIT 7
`endif

// File: dsap_dbg_host.sv
/*
  debugger model: bit-banged tap master with reset and scan tasks.
  assumes tck stands still between frames and tdi idles high (pull-up).
*/
`timescale 1ns/100ps
module dsap_dbg_host (
  // tap pins
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // one period; tdo sampled at the rise, inputs moved after the fall
  task automatic tick(input logic m, input logic d, output logic q);
    #1 o_tms = m;
    o_tdi = d;
    #23 o_tck = 1'b1;
    q = i_tdo;
    #24 o_tck = 1'b0;
  endtask
  // five ones reach reset from any state, then park in idle
  task automatic tap_reset();
    logic q;
    #1.3;
    repeat (5) tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
  endtask
  // idle to shift, n bits lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [127:0] d,
                      output logic [31:0] q);
    logic b;
    #1.3;
    q = '0;
    tick(1'b1, 1'b1, b);
    if (ir)
      tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
    tick(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, d[i], b);
      if (i < 32)
        q[i] = b;
    end
    tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
    o_tdi = 1'b1;
  endtask
endmodule // dsap_dbg_host

// File: dsap_msg_mem.sv
/*
  debug message register store: one byte plus dirty flag, registered read.
  assumes cpu-side clock; debugger clear arrives already synchronised.
*/
`timescale 1ns/100ps
`include "dsap_cfg.svh"
module dsap_msg_mem (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // cpu access
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd,
  // debugger clear pulse
  input wire logic i_clr,
  // outputs
  output logic [7:0] o_rdata,
  output logic [7:0] o_byte,
  output logic o_dirty
);
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_byte <= 8'h00;
    end else if (i_wr) begin
      o_byte <= i_wdata;
    end
  end
  // write wins over clear so a fresh byte is never dropped
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dirty <= 1'b0;
    end else if (i_wr) begin
      o_dirty <= 1'b1;
    end else if (i_clr) begin
      o_dirty <= 1'b0;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= {o_dirty, o_byte[6:0]};
    end
  end
endmodule // dsap_msg_mem

// File: dsap_pkg.sv
package dsap_pkg;
  typedef enum logic [1:0] {
    DSAP_BPM_SINGLE,
    DSAP_BPM_PRANGE,
    DSAP_BPM_DRANGE,
    DSAP_BPM_OFF
  } dsap_bp_mode_t;
  typedef struct packed {
    logic [15:0] pc;
    logic pc_valid;
    logic flow_change;
    logic [15:0] daddr;
    logic daddr_valid;
  } dsap_cpu_trace_t;
  typedef struct packed {
    logic tap_enable_fuse;
    logic debug_enable_fuse;
    logic lock_bit_one;
    logic lock_bit_two;
  } dsap_fuses_t;
  typedef struct packed {
    logic [7:0] out_data;
    logic [7:0] out_en;
  } dsap_pin_drive_t;
endpackage

// File: dsap_top.sv
/*
  test access port with boundary ring, scan reset, debug gating, breakpoint
  unit and cpu-to-debugger message byte.
  assumes i_tck is the debugger clock; fuses are stable levels.
*/
// Notes on behaviour
// - four breakpoints: two program, two combined
// - combined pair: single each or one range
// - halt on flow change or single step
// - debugger drives cpu chain, reads results; here capture loads nothing into the cpu chain, tdo returns the word shifted in
// - debug needs both fuses, no lock bits
// - codes 8 to b are debug ops
// - cpu write stores byte, sets dirty
// - read gives low seven bits plus dirty
// - shared address reaches debug only when enabled
// - port needs fuse and disable bit clear
// - port programs flash, eeprom, fuses, locks; here only o_fuse_prog_ok gates fuse programming
// - locks block debug fuse until erase
// - idcode is the default instruction
// - reset puts port pins high impedance
// - reset from pin or scan reset bit
// - extest drives latches immediately on load
// - sample captures pins without disturbing
// - scan runs without the chip clock
// - four bit instruction register codes
// - sixteen state controller from tms
// - shift registers move lsb first
// - one bit unlatched scan reset register
`timescale 1ns/100ps
`include "dsap_cfg.svh"
module dsap_top (
  // system clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_ext_rst_b,
  // tap pins
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe,
  // fuses and control
  input wire dsap_pkg::dsap_fuses_t i_fuses,
  input wire logic i_tap_disable_bit,
  input wire logic i_chip_erase_done,
  input wire logic i_fuse_prog_req,
  output logic o_fuse_prog_ok,
  // port pins
  input wire logic [7:0] i_pin_in,
  input wire dsap_pkg::dsap_pin_drive_t i_core_drive,
  output dsap_pkg::dsap_pin_drive_t o_pin_drive,
  output logic o_core_rst_b,
  // cpu side
  input wire dsap_pkg::dsap_cpu_trace_t i_trace,
  input wire logic i_msg_wr,
  input wire logic i_msg_rd,
  input wire logic [7:0] i_msg_wdata,
  input wire logic i_msg_shared,
  output logic [7:0] o_msg_rdata,
  output logic o_msg_hit,
  output logic [15:0] o_cpu_instr,
  output logic o_cpu_instr_vld,
  output logic o_break
);
  import dsap_pkg::*;
  typedef enum logic [3:0] {
    TLR, RTI, SDR, CDR, SHDR, E1DR, PDR, E2DR, UDR,
    SIR, CIR, SHIR, E1IR, PIR, E2IR, UIR
  } dsap_tap_st_t;

  // port enable is a fuse level; pin resync of the disable bit not needed
  logic port_en;
  logic dbg_en;
  assign port_en = i_fuses.tap_enable_fuse & ~i_tap_disable_bit;
  assign dbg_en = port_en & i_fuses.debug_enable_fuse &
    ~i_fuses.lock_bit_one & ~i_fuses.lock_bit_two;

  // tck domain: controller, everything below runs without the chip clock
  dsap_tap_st_t st_q;
  dsap_tap_st_t st_d;
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      TLR: st_d = i_tms ? TLR : RTI;
      RTI: st_d = i_tms ? SDR : RTI;
      SDR: st_d = i_tms ? SIR : CDR;
      CDR: st_d = i_tms ? E1DR : SHDR;
      SHDR: st_d = i_tms ? E1DR : SHDR;
      E1DR: st_d = i_tms ? UDR : PDR;
      PDR: st_d = i_tms ? E2DR : PDR;
      E2DR: st_d = i_tms ? UDR : SHDR;
      UDR: st_d = i_tms ? SDR : RTI;
      SIR: st_d = i_tms ? TLR : CIR;
      CIR: st_d = i_tms ? E1IR : SHIR;
      SHIR: st_d = i_tms ? E1IR : SHIR;
      E1IR: st_d = i_tms ? UIR : PIR;
      PIR: st_d = i_tms ? E2IR : PIR;
      E2IR: st_d = i_tms ? UIR : SHIR;
      UIR: st_d = i_tms ? SDR : RTI;
    endcase
  end
  // port disabled holds the controller in reset
  always_ff @(posedge i_tck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= TLR;
    end else if (!port_en) begin
      st_q <= TLR;
    end else begin
      st_q <= st_d;
    end
  end

  logic [3:0] ir_sh_q;
  logic [3:0] ir_q;
  always_ff @(posedge i_tck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ir_sh_q <= 4'h0;
    end else if (st_q == CIR) begin
      ir_sh_q <= `DSAP_IR_CAPTURE;
    end else if (st_q == SHIR) begin
      ir_sh_q <= {i_tdi, ir_sh_q[3:1]};
    end
  end
  always_ff @(posedge i_tck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ir_q <= `DSAP_IR_IDCODE;
    end else if (st_q == TLR) begin
      ir_q <= `DSAP_IR_IDCODE;
    end else if (st_q == UIR) begin
      ir_q <= ir_sh_q;
    end
  end

  // instruction decode; debug ops fall to bypass when debug is off
  logic sel_bsr;
  logic sel_id;
  logic sel_rst;
  logic sel_dbg;
  logic sel_bp;
  logic sel_cpu;
  logic sel_msg;
  assign sel_bsr = (ir_q == `DSAP_IR_EXTEST) || (ir_q == `DSAP_IR_SAMPLE);
  assign sel_id = (ir_q == `DSAP_IR_IDCODE);
  assign sel_rst = (ir_q == `DSAP_IR_SRESET);
  assign sel_dbg = dbg_en && (ir_q[3:2] == 2'b10);
  assign sel_bp = sel_dbg && (ir_q == `DSAP_IR_DBG0);
  assign sel_cpu = sel_dbg && (ir_q == `DSAP_IR_DBG1);
  assign sel_msg = sel_dbg && (ir_q == `DSAP_IR_DBG2);

  // data shift registers; dbg3 selects no path of its own
  logic [31:0] id_q;
  logic byp_q;
  logic rst_q;
  logic [`DSAP_BSR_W-1:0] bsr_q;
  logic [`DSAP_BSR_W-1:0] bsr_upd_q;
  logic [`DSAP_BPC_W-1:0] bpc_q;
  logic [`DSAP_BPC_W-1:0] bpc_upd_q;
  logic [`DSAP_CPU_W-1:0] cpu_sh_q;
  logic [7:0] msg_sh_q;
  logic cdr;
  logic shdr;
  assign cdr = (st_q == CDR);
  assign shdr = (st_q == SHDR);
  logic [7:0] msg_tck_q;
  logic msg_dirty_tck_q;
  always_ff @(posedge i_tck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      id_q <= 32'h0;
      byp_q <= 1'b0;
    end else if (cdr) begin
      id_q <= {`DSAP_ID_VERSION, `DSAP_ID_PART, `DSAP_ID_MAKER, 1'b1};
      byp_q <= 1'b0;
    end else if (shdr) begin
      id_q <= {i_tdi, id_q[31:1]};
      byp_q <= i_tdi;
    end
  end
  // unlatched: the shift stage itself holds the core in reset
  always_ff @(posedge i_tck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_q <= 1'b0;
    end else if (shdr && sel_rst) begin
      rst_q <= i_tdi;
    end
  end
  // pin snapshot is sampled only, the core keeps running
  logic [`DSAP_BSR_W-1:0] bsr_cap;
  assign bsr_cap = {i_pin_in, i_core_drive.out_data, i_core_drive.out_en};
  always_ff @(posedge i_tck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bsr_q <= '0;
      bsr_upd_q <= '0;
    end else if (cdr && sel_bsr) begin
      bsr_q <= bsr_cap;
    end else if (shdr && sel_bsr) begin
      bsr_q <= {i_tdi, bsr_q[`DSAP_BSR_W-1:1]};
    end else if (st_q == UDR && sel_bsr) begin
      bsr_upd_q <= bsr_q;
    end
  end
  always_ff @(posedge i_tck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bpc_q <= '0;
      bpc_upd_q <= '0;
    end else if (!dbg_en) begin
      bpc_upd_q <= '0;
    end else if (cdr && sel_bp) begin
      bpc_q <= bpc_upd_q;
    end else if (shdr && sel_bp) begin
      bpc_q <= {i_tdi, bpc_q[`DSAP_BPC_W-1:1]};
    end else if (st_q == UDR && sel_bp) begin
      bpc_upd_q <= bpc_q;
    end
  end
  always_ff @(posedge i_tck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cpu_sh_q <= '0;
      msg_sh_q <= '0;
    end else if (cdr) begin
      msg_sh_q <= msg_tck_q;
    end else if (shdr && sel_cpu) begin
      cpu_sh_q <= {i_tdi, cpu_sh_q[`DSAP_CPU_W-1:1]};
    end else if (shdr && sel_msg) begin
      msg_sh_q <= {i_tdi, msg_sh_q[7:1]};
    end
  end

  // tdo mux, changes on falling tck as the port standard expects
  logic tdo_mux;
  always_comb begin
    tdo_mux = byp_q;
    if (st_q == SHIR) tdo_mux = ir_sh_q[0];
    else if (sel_id) tdo_mux = id_q[0];
    else if (sel_bsr) tdo_mux = bsr_q[0];
    else if (sel_rst) tdo_mux = rst_q;
    else if (sel_bp) tdo_mux = bpc_q[0];
    else if (sel_cpu) tdo_mux = cpu_sh_q[0];
    else if (sel_msg) tdo_mux = msg_sh_q[0];
  end
  always_ff @(negedge i_tck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else begin
      o_tdo <= tdo_mux;
      o_tdo_oe <= (st_q == SHIR) || (st_q == SHDR);
    end
  end

  // crossings into tck: message byte is quasi-static, dirty by two flops
  logic dirty_m1_q;
  logic msg_dirty;
  logic [7:0] msg_byte;
  always_ff @(posedge i_tck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dirty_m1_q <= 1'b0;
      msg_dirty_tck_q <= 1'b0;
      msg_tck_q <= 8'h00;
    end else begin
      dirty_m1_q <= msg_dirty;
      msg_dirty_tck_q <= dirty_m1_q;
      if (msg_dirty_tck_q) msg_tck_q <= msg_byte;
    end
  end
  // clear request toggles on update of the message op, edge-detected in sys domain
  logic clr_tgl_q;
  always_ff @(posedge i_tck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clr_tgl_q <= 1'b0;
    end else if (st_q == UDR && sel_msg) begin
      clr_tgl_q <= ~clr_tgl_q;
    end
  end
  // cpu instruction word toggle
  logic ins_tgl_q;
  logic [`DSAP_CPU_W-1:0] ins_q;
  always_ff @(posedge i_tck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ins_tgl_q <= 1'b0;
      ins_q <= '0;
    end else if (st_q == UDR && sel_cpu) begin
      ins_tgl_q <= ~ins_tgl_q;
      ins_q <= cpu_sh_q;
    end
  end

  // sys domain synchronisers
  logic [2:0] clr_s_q;
  logic [2:0] ins_s_q;
  logic [1:0] dbg_s_q;
  logic [1:0] ext_s_q;
  logic [1:0] srst_s_q;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clr_s_q <= 3'h0;
      ins_s_q <= 3'h0;
      dbg_s_q <= 2'h0;
      ext_s_q <= 2'h3;
      srst_s_q <= 2'h0;
    end else begin
      clr_s_q <= {clr_s_q[1:0], clr_tgl_q};
      ins_s_q <= {ins_s_q[1:0], ins_tgl_q};
      dbg_s_q <= {dbg_s_q[0], dbg_en};
      ext_s_q <= {ext_s_q[0], i_ext_rst_b};
      srst_s_q <= {srst_s_q[0], rst_q};
    end
  end
  logic msg_clr;
  assign msg_clr = clr_s_q[2] ^ clr_s_q[1];

  // shared address routing
  logic msg_sel;
  assign msg_sel = ~i_msg_shared | (i_fuses.debug_enable_fuse & dbg_s_q[1]);
  logic [7:0] msg_rdata;
  dsap_msg_mem u_msg (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_wr(i_msg_wr & msg_sel),
    .i_wdata(i_msg_wdata),
    .i_rd(i_msg_rd & msg_sel),
    .i_clr(msg_clr),
    .o_rdata(msg_rdata),
    .o_byte(msg_byte),
    .o_dirty(msg_dirty)
  );
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_msg_hit <= 1'b0;
      o_cpu_instr <= '0;
      o_cpu_instr_vld <= 1'b0;
      o_fuse_prog_ok <= 1'b0;
    end else begin
      o_msg_hit <= i_msg_rd & msg_sel;
      o_cpu_instr_vld <= ins_s_q[2] ^ ins_s_q[1];
      if (ins_s_q[2] ^ ins_s_q[1]) o_cpu_instr <= ins_q;
      o_fuse_prog_ok <= i_fuse_prog_req & (i_chip_erase_done |
        ~(i_fuses.lock_bit_one | i_fuses.lock_bit_two));
    end
  end
  assign o_msg_rdata = msg_rdata;

  // breakpoint compare in sys domain; config crosses as quasi-static
  logic [`DSAP_NBP-1:0] hit;
  dsap_bp_mode_t bp_mode;
  assign bp_mode = dsap_bp_mode_t'(bpc_upd_q[`DSAP_BP_MODE_LSB +: 2]);
  genvar g;
  generate
    for (g = 0; g < `DSAP_NBP; g++) begin : g_bp
      logic [15:0] a;
      logic en;
      logic is_data;
      logic [15:0] ref_a;
      logic h;
      assign hit[g] = h;
      assign a = bpc_upd_q[g*18 +: 16];
      assign en = bpc_upd_q[g*18+16];
      // only the combined pair may watch data
      assign is_data = (g >= 2) && bpc_upd_q[g*18+17];
      assign ref_a = is_data ? i_trace.daddr : i_trace.pc;
      always_comb begin
        h = 1'b0;
        if (g < 2 || bp_mode == DSAP_BPM_SINGLE) begin
          h = en && (is_data ? i_trace.daddr_valid : i_trace.pc_valid)
            && (ref_a == a);
        end else if (g == 2 && bp_mode != DSAP_BPM_OFF) begin
          // bp3 address field acts as mask for the range
          h = en && ((bp_mode == DSAP_BPM_PRANGE) ?
            i_trace.pc_valid && (((i_trace.pc ^ a) & bpc_upd_q[69:54]) == '0)
            : i_trace.daddr_valid &&
            (((i_trace.daddr ^ a) & bpc_upd_q[69:54]) == '0));
        end
      end
    end
  endgenerate
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_break <= 1'b0;
    end else begin
      o_break <= dbg_s_q[1] && ((|hit) ||
        (bpc_upd_q[`DSAP_BP_FLOW_BIT] && i_trace.flow_change) ||
        (bpc_upd_q[`DSAP_BP_STEP_BIT] && i_trace.pc_valid));
    end
  end

  // core reset: assert registered on the chip clock after synchronisers, any source
  logic core_rst_q;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      core_rst_q <= 1'b1;
      o_core_rst_b <= 1'b0;
    end else begin
      core_rst_q <= ~ext_s_q[1] | srst_s_q[1];
      o_core_rst_b <= ext_s_q[1] & ~srst_s_q[1];
    end
  end
  // pins: extest drives on load; core reset floats outputs
  logic extest;
  assign extest = port_en && (ir_q == `DSAP_IR_EXTEST);
  always_comb begin
    o_pin_drive = i_core_drive;
    if (extest) begin
      o_pin_drive.out_en = bsr_upd_q[7:0];
      o_pin_drive.out_data = bsr_upd_q[15:8];
    end else if (core_rst_q || rst_q) begin
      o_pin_drive.out_en = 8'h00;
    end
  end

  property p_dirty_set;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_msg_wr && msg_sel) |=> msg_dirty;
  endproperty
  a_dirty_set: assert property (p_dirty_set)
    else $error("dirty not set after write");
  property p_idle_reset;
    @(posedge i_tck) disable iff (!i_rst_b)
      (st_q == TLR) |=> (ir_q == `DSAP_IR_IDCODE);
  endproperty
  a_idle_reset: assert property (p_idle_reset)
    else $error("ir not idcode after reset state");
  property p_tms5;
    @(posedge i_tck) disable iff (!i_rst_b)
      i_tms [*5] |=> (st_q == TLR);
  endproperty
  a_tms5: assert property (p_tms5)
    else $error("tms high five times did not reset");
  property p_gate;
    @(posedge i_tck) disable iff (!i_rst_b)
      (!dbg_en && shdr && ir_q[3:2] == 2'b10) |-> (tdo_mux == byp_q);
  endproperty
  a_gate: assert property (p_gate)
    else $error("debug path open while locked");
  property p_extest;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      extest |-> (o_pin_drive.out_en == bsr_upd_q[7:0]);
  endproperty
  a_extest: assert property (p_extest)
    else $error("extest latches not on pins");
  property p_hiz;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (core_rst_q && !extest) |-> (o_pin_drive.out_en == 8'h00);
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("pins driven in reset");
  property p_srst;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      $rose(srst_s_q[1]) |=> core_rst_q;
  endproperty
  a_srst: assert property (p_srst)
    else $error("scan reset ignored");
  property p_read;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_msg_rd && msg_sel && !i_msg_wr) |=>
        (msg_rdata[7] == $past(msg_dirty));
  endproperty
  a_read: assert property (p_read)
    else $error("msb is not dirty flag");
  c_extest: cover property (@(posedge i_tck) st_q == UIR ##1 extest);
  c_clr: cover property (@(posedge i_sys_clk) msg_dirty ##1 msg_clr);
  c_brk: cover property (@(posedge i_sys_clk) o_break);
endmodule // dsap_top

// File: dsap_top_tb.sv
/*
  self-checking bench for dsap_top, debugger model on the tap pins.
  assumes ring layout unknown, so only an all-ones preload is predicted.
*/
`timescale 1ns/100ps
`include "dsap_cfg.svh"
`define CHK(e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g); end end
module dsap_top_tb;
  import dsap_pkg::*;
  localparam logic [31:0] ID = {`DSAP_ID_VERSION, `DSAP_ID_PART,
    `DSAP_ID_MAKER, 1'b1};
  logic i_sys_clk = 1'b0;
  logic clk_run = 1'b1;
  logic i_rst_b = 1'b0;
  logic i_ext_rst_b = 1'b1;
  logic i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe, o_fuse_prog_ok, o_core_rst_b;
  dsap_fuses_t i_fuses = 4'hc;
  logic i_tap_disable_bit = 1'b0;
  logic i_chip_erase_done = 1'b0;
  logic i_fuse_prog_req = 1'b0;
  logic [7:0] i_pin_in = 8'h00;
  dsap_pin_drive_t i_core_drive = '0;
  dsap_pin_drive_t o_pin_drive;
  dsap_cpu_trace_t i_trace = '0;
  logic i_msg_wr = 1'b0;
  logic i_msg_rd = 1'b0;
  logic i_msg_shared = 1'b0;
  logic [7:0] i_msg_wdata = 8'h00;
  logic [7:0] o_msg_rdata;
  logic o_msg_hit, o_cpu_instr_vld, o_break;
  logic [15:0] o_cpu_instr;
  logic [31:0] lf = 32'hc7a9;
  logic [31:0] got, e_w, g_w;
  logic [31:0] exp_q[$];
  logic [31:0] got_q[$];
  int n_fail = 0;
  int num_checks = 0;
  int oe_hits = 0;
  // gate lets the chip clock stop for the scan-only run
  always #2 i_sys_clk = clk_run ? ~i_sys_clk : i_sys_clk;
  dsap_top uut (.i_sys_clk, .i_rst_b, .i_ext_rst_b, .i_tck, .i_tms,
    .i_tdi, .o_tdo, .o_tdo_oe, .i_fuses, .i_tap_disable_bit,
    .i_chip_erase_done, .i_fuse_prog_req, .o_fuse_prog_ok, .i_pin_in,
    .i_core_drive, .o_pin_drive, .o_core_rst_b, .i_trace, .i_msg_wr,
    .i_msg_rd, .i_msg_wdata, .i_msg_shared, .o_msg_rdata, .o_msg_hit,
    .o_cpu_instr, .o_cpu_instr_vld, .o_break);
  dsap_dbg_host host (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi),
    .i_tdo(o_tdo));
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic note(input logic [31:0] e);
    exp_q.push_back(e);
  endtask
  task automatic post(input logic [31:0] g);
    got_q.push_back(g);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  // sample just past the edge so registered outputs have landed
  task automatic settle(input int n);
    cyc(n);
    #1;
  endtask
  task automatic ir(input logic [3:0] c);
    note(32'h1);
    host.scan(1'b1, 4, {28'h0, c}, got);
    post({28'h0, got[3:0]});
  endtask
  task automatic dr(input int n, input logic [31:0] d);
    host.scan(1'b0, n, d, got);
    post(got);
  endtask
  task automatic tally_and_finish();
    n_fail += exp_q.size();
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // result monitors: message reads and cpu chain words
  always @(posedge i_sys_clk) begin
    if (o_msg_hit)
      post({24'h0, o_msg_rdata});
    if (o_cpu_instr_vld)
      post({16'h0, o_cpu_instr});
  end
  always @(posedge i_tck)
    if (o_tdo_oe)
      oe_hits++;
  initial forever begin
    wait (got_q.size() > 0);
    e_w = exp_q.pop_front();
    g_w = got_q.pop_front();
    `CHK(e_w, g_w)
  end
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    cyc(20);
    i_rst_b <= 1'b1;
    cyc(3);
    host.tap_reset();
    note(ID);
    dr(32, lf);
    clk_run = 1'b0;
    host.tap_reset();
    note(ID);
    dr(32, ~lf);
    clk_run = 1'b1;
    cyc(2);
    ir(`DSAP_IR_BYPASS);
    lf = nxt(lf);
    note({lf[6:0], 1'b0});
    dr(8, lf);
    // pin reset, then scan reset; pins must float while held
    @(posedge i_sys_clk);
    i_core_drive <= {lf[15:8], 8'hff};
    i_pin_in <= lf[31:24];
    ir(`DSAP_IR_SRESET);
    for (int k = 0; k < 2; k++) begin
      @(posedge i_sys_clk);
      if (k == 0)
        i_ext_rst_b <= 1'b0;
      else
        host.scan(1'b0, 1, 32'h1, got);
      settle(6);
      note(32'h0);
      post(o_core_rst_b);
      note(32'h0);
      post(o_pin_drive.out_en);
      @(posedge i_sys_clk);
      i_ext_rst_b <= 1'b1;
      host.scan(1'b0, 1, 32'h0, got);
      settle(10);
      note(32'h1);
      post(o_core_rst_b);
    end
    ir(`DSAP_IR_SAMPLE);
    settle(2);
    note(i_core_drive);
    post(o_pin_drive);
    host.scan(1'b0, `DSAP_BSR_W, 32'hffffffff, got);
    ir(`DSAP_IR_EXTEST);
    settle(1);
    note(32'hffff);
    post(o_pin_drive);
    host.tap_reset();
    // cpu writes a byte, reads it back, debugger fetches it
    @(posedge i_sys_clk);
    i_msg_wdata <= lf[23:16];
    i_msg_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_msg_wr <= 1'b0;
    i_msg_rd <= 1'b1;
    note({1'b1, lf[22:16]});
    @(posedge i_sys_clk);
    i_msg_rd <= 1'b0;
    cyc(3);
    ir(`DSAP_IR_DBG2);
    note(lf[23:16]);
    dr(8, 32'h0);
    cyc(10);
    i_msg_rd <= 1'b1;
    note({1'b0, lf[22:16]});
    @(posedge i_sys_clk);
    i_msg_rd <= 1'b0;
    cyc(3);
    ir(`DSAP_IR_DBG1);
    note(lf[15:0]);
    host.scan(1'b0, 16, lf, got);
    cyc(10);
    // lock set, then debug fuse off: every debug op acts as bypass
    for (int k = 0; k < 2; k++) begin
      @(posedge i_sys_clk);
      i_fuses <= (k == 0) ? 4'he : 4'h8;
      cyc(2);
      for (int c = 8; c < 12; c++) begin
        ir(c[3:0]);
        lf = nxt(lf);
        note({lf[6:0], 1'b0});
        dr(8, lf);
      end
    end
    // shared address, debug fuse off: neither write nor read routed
    @(posedge i_sys_clk);
    i_msg_shared <= 1'b1;
    i_msg_wr <= 1'b1;
    i_msg_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_msg_wr <= 1'b0;
    i_msg_rd <= 1'b0;
    #1;
    note(32'h0);
    post(o_msg_hit);
    cyc(1);
    i_fuses <= 4'hc;
    cyc(3);
    i_msg_rd <= 1'b1;
    note(32'h1);
    @(posedge i_sys_clk);
    i_msg_rd <= 1'b0;
    #1;
    post(o_msg_hit);
    note({1'b0, i_msg_wdata[6:0]});
    // breakpoint 0 on a random address, flow-change break on
    ir(`DSAP_IR_DBG0);
    lf = nxt(lf);
    host.scan(1'b0, `DSAP_BPC_W, {4'b0100, 54'h0, 2'b01, lf[15:0]}, got);
    @(posedge i_sys_clk);
    i_trace <= {~lf[15:0], 19'h40000};
    settle(2);
    note(32'h0);
    post(o_break);
    @(posedge i_sys_clk);
    i_trace <= {lf[15:0], 19'h40000};
    settle(2);
    note(32'h1);
    post(o_break);
    @(posedge i_sys_clk);
    i_trace <= {16'h0, 19'h20000};
    settle(2);
    note(32'h1);
    post(o_break);
    @(posedge i_sys_clk);
    i_trace <= '0;
    for (int k = 0; k < 8; k++) begin
      @(posedge i_sys_clk);
      i_fuses <= {2'b11, k[1:0]};
      i_chip_erase_done <= k[2];
      i_fuse_prog_req <= 1'b1;
      settle(2);
      note(k[2] | ~|k[1:0]);
      post(o_fuse_prog_ok);
    end
    // disable bit set, then port fuse off: tdo never enabled
    for (int k = 0; k < 2; k++) begin
      @(posedge i_sys_clk);
      i_fuses <= (k == 0) ? 4'hc : 4'h4;
      i_tap_disable_bit <= (k == 0);
      cyc(2);
      oe_hits = 0;
      host.tap_reset();
      host.scan(1'b0, 32, lf, got);
      note(32'h0);
      post(oe_hits);
    end
    wait (got_q.size() == 0);
    cyc(2);
    tally_and_finish();
  end
endmodule // dsap_top_tb
